// file: pkg/mswk_regs.vh
/*
 constants for the magnetic measure and wake-up sequencer.
 assumes inclusion by bare name from the design files only.
*/
`ifndef MSWK_REGS_VH
`define MSWK_REGS_VH
// clock rate in MHz
`define MSWK_CLK_MHZ 100
// settle times in ns
`define MSWK_BIAS_NS 200
`define MSWK_FOSC_NS 100
`define MSWK_HALL_NS 300
// interrupt pulse length in ns
`define MSWK_INT_NS 1000
// channel codes on the multiplexer
`define MSWK_CH_X 2'h0
`define MSWK_CH_Y 2'h1
`define MSWK_CH_Z 2'h2
`define MSWK_CH_T 2'h3
// widths
`define MSWK_MAG_W 12
`define MSWK_TMP_W 10
// reset value of temperature step enable
`define MSWK_TEMP_EN_RST 1'b1
`endif

// file: hdl/mswk_top.v
/*
 measurement sequencer and wake-up comparator of a three-axis magnetic sensor.
 assumes a converter on core_clk, a supply level from the analog side,
 configuration strobes from the serial unit, and raw bus pins from outside.
*/
`include "mswk_regs.vh"
module mswk_top #(
   parameter MAG_W = `MSWK_MAG_W,
   parameter TMP_W = `MSWK_TMP_W
) (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // configuration from the serial unit
   input wire cfg_write,
   input wire cfg_temp_en,
   input wire cfg_wake_en,
   input wire cfg_ca_en,
   input wire meas_trig,
   input wire [MAG_W-1:0] thr_hi_x,
   input wire [MAG_W-1:0] thr_lo_x,
   input wire [MAG_W-1:0] thr_hi_y,
   input wire [MAG_W-1:0] thr_lo_y,
   input wire [MAG_W-1:0] thr_hi_z,
   input wire [MAG_W-1:0] thr_lo_z,
   // analog side
   input wire supply_ok,
   input wire [MAG_W-1:0] adc_data,
   input wire adc_done,
   output reg bias_en,
   output reg fosc_en,
   output reg hall_bias_en,
   output reg [1:0] mux_sel,
   output reg adc_start,
   // results
   output reg [MAG_W-1:0] res_x,
   output reg [MAG_W-1:0] res_y,
   output reg [MAG_W-1:0] res_z,
   output reg [TMP_W-1:0] res_t,
   output reg res_valid,
   output reg busy_meas,
   // bus pins
   input wire scl_in,
   input wire sda_in,
   input wire sda_low_req,
   output reg scl_out,
   output reg scl_oe,
   output reg sda_out,
   output reg sda_oe
);
   localparam BIAS_CYC = (`MSWK_BIAS_NS * `MSWK_CLK_MHZ + 999) / 1000;
   localparam FOSC_CYC = (`MSWK_FOSC_NS * `MSWK_CLK_MHZ + 999) / 1000;
   localparam HALL_CYC = (`MSWK_HALL_NS * `MSWK_CLK_MHZ + 999) / 1000;
   localparam INT_CYC = (`MSWK_INT_NS * `MSWK_CLK_MHZ) / 1000;

   localparam [7:0] S_LOWP = 8'h01;
   localparam [7:0] S_BIAS = 8'h02;
   localparam [7:0] S_CHK = 8'h04;
   localparam [7:0] S_FOSC = 8'h08;
   localparam [7:0] S_HALL = 8'h10;
   localparam [7:0] S_CONV = 8'h20;
   localparam [7:0] S_WAIT = 8'h40;
   localparam [7:0] S_HALT = 8'h80;

   // signed compare of one axis against its window
   function out_of_win;
      input [MAG_W-1:0] v;
      input [MAG_W-1:0] hi;
      input [MAG_W-1:0] lo;
      begin
         out_of_win = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
      end
   endfunction

   // synchronisers: supply, scl, sda
   reg [2:0] sync1_reg;
   reg [2:0] sync2_reg;
   reg scl_d_reg;
   reg sda_d_reg;
   wire sup_ok = sync2_reg[0];
   wire scl_s = sync2_reg[1];
   wire sda_s = sync2_reg[2];

   reg [7:0] state_reg;
   reg [7:0] state_next;
   reg [7:0] cnt_reg;
   reg [7:0] cnt_next;
   reg configured_reg;
   reg temp_en_reg;
   reg wake_en_reg;
   reg ca_en_reg;
   reg bus_busy_reg;
   reg int_pend_reg;
   reg [7:0] int_cnt_reg;
   reg cyc_done;

   // start seen while clock high marks the bus busy, stop seen while clock high marks it idle
   wire start_seen = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_seen = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   wire bus_idle = !bus_busy_reg && scl_s && sda_s;

   wire last_ch = temp_en_reg ? (mux_sel == `MSWK_CH_T) : (mux_sel == `MSWK_CH_Z);

   // window outcome of the new set, OR over three axes
   wire wake_hit = out_of_win(res_x, thr_hi_x, thr_lo_x)
      || out_of_win(res_y, thr_hi_y, thr_lo_y)
      || out_of_win(res_z, thr_hi_z, thr_lo_z);

   always @(posedge core_clk) begin
      if (!rstn) begin
         // pins idle high so no false edge after reset, supply taken as low
         sync1_reg <= 3'h6;
         sync2_reg <= 3'h6;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         sync1_reg <= {sda_in, scl_in, supply_ok};
         sync2_reg <= sync1_reg;
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // configuration latch
   always @(posedge core_clk) begin
      if (!rstn) begin
         configured_reg <= 1'b0;
         temp_en_reg <= `MSWK_TEMP_EN_RST;
         wake_en_reg <= 1'b0;
         ca_en_reg <= 1'b0;
      end else if (cfg_write) begin
         configured_reg <= 1'b1;
         temp_en_reg <= cfg_temp_en;
         wake_en_reg <= cfg_wake_en;
         ca_en_reg <= cfg_ca_en;
      end
   end

   // sequencer
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cyc_done = 1'b0;
      case (state_reg)
         S_LOWP: begin
            // nothing measured until the master has configured us
            if (cfg_write || (configured_reg && meas_trig)) begin
               state_next = S_BIAS;
               cnt_next = BIAS_CYC[7:0];
            end
         end
         S_BIAS: begin
            if (cnt_reg == 8'h00) begin
               state_next = S_CHK;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         S_CHK: begin
            state_next = S_FOSC;
            cnt_next = FOSC_CYC[7:0];
         end
         S_FOSC: begin
            if (cnt_reg == 8'h00) begin
               state_next = S_HALL;
               cnt_next = HALL_CYC[7:0];
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         S_HALL: begin
            if (cnt_reg == 8'h00) begin
               state_next = S_CONV;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         S_CONV: begin
            state_next = S_WAIT;
         end
         S_WAIT: begin
            if (adc_done) begin
               if (last_ch) begin
                  state_next = S_LOWP;
                  cyc_done = 1'b1;
               end else begin
                  state_next = S_CONV;
               end
            end
         end
         S_HALT: begin
            if (sup_ok) begin
               state_next = S_BIAS;
               cnt_next = BIAS_CYC[7:0];
            end
         end
         default: begin
            state_next = S_LOWP;
         end
      endcase
      // a supply dip anywhere in a cycle halts it, and it restarts from bias when supply returns
      if (!sup_ok && state_reg != S_LOWP && state_reg != S_HALT) begin
         state_next = S_HALT;
         cyc_done = 1'b0;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= S_LOWP;
         cnt_reg <= 8'h00;
         mux_sel <= `MSWK_CH_X;
         adc_start <= 1'b0;
         bias_en <= 1'b0;
         fosc_en <= 1'b0;
         hall_bias_en <= 1'b0;
         busy_meas <= 1'b0;
         res_x <= {MAG_W{1'b0}};
         res_y <= {MAG_W{1'b0}};
         res_z <= {MAG_W{1'b0}};
         res_t <= {TMP_W{1'b0}};
         res_valid <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         adc_start <= (state_next == S_CONV);
         bias_en <= (state_next != S_LOWP) && (state_next != S_HALT);
         fosc_en <= state_next[3] | state_next[4] | state_next[5] | state_next[6];
         hall_bias_en <= state_next[4] | state_next[5] | state_next[6];
         busy_meas <= (state_next != S_LOWP);
         res_valid <= cyc_done;
         if (state_next == S_BIAS) begin
            mux_sel <= `MSWK_CH_X;
         end else if (state_reg == S_WAIT && adc_done && !last_ch && sup_ok) begin
            mux_sel <= mux_sel + 2'h1;
         end
         if (state_reg == S_WAIT && adc_done && sup_ok) begin
            case (mux_sel)
               `MSWK_CH_X: res_x <= adc_data;
               `MSWK_CH_Y: res_y <= adc_data;
               `MSWK_CH_Z: res_z <= adc_data;
               default: res_t <= adc_data[MAG_W-1:MAG_W-TMP_W];
            endcase
         end
      end
   end

   // bus activity and interrupt pulse on the clock pin
   always @(posedge core_clk) begin
      if (!rstn) begin
         bus_busy_reg <= 1'b0;
         int_pend_reg <= 1'b0;
         int_cnt_reg <= 8'h00;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         // own pulse pulls scl low, which must not count as traffic
         if (start_seen && int_cnt_reg == 8'h00) begin
            bus_busy_reg <= 1'b1;
         end else if (stop_seen) begin
            bus_busy_reg <= 1'b0;
         end
         sda_oe <= sda_low_req;
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         if (int_cnt_reg != 8'h00) begin
            int_cnt_reg <= int_cnt_reg - 8'h01;
            scl_oe <= (int_cnt_reg != 8'h01);
         end else if (int_pend_reg && bus_idle) begin
            int_pend_reg <= 1'b0;
            int_cnt_reg <= INT_CYC[7:0];
            scl_oe <= 1'b1;
         end else if (int_pend_reg && ca_en_reg && bus_busy_reg) begin
            int_pend_reg <= 1'b0;
            scl_oe <= 1'b0;
         end else begin
            scl_oe <= 1'b0;
         end
         // raised the cycle after results land, so compare sees new values
         if (res_valid && (!wake_en_reg || wake_hit)) begin
            int_pend_reg <= 1'b1;
         end
      end
   end
endmodule

// file: sim/mswk_monitor.sv
/* checker of sequencer and pin ports.
 assumes bind onto mswk_top. */
module mswk_monitor (
   // clock, reset, inputs
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cfg_write,
   input wire logic meas_trig,
   input wire logic supply_ok,
   input wire logic adc_done,
   input wire logic sda_low_req,
   input wire logic scl_in,
   input wire logic sda_in,
   // outputs
   input wire logic bias_en,
   input wire logic fosc_en,
   input wire logic hall_bias_en,
   input wire logic [1:0] mux_sel,
   input wire logic adc_start,
   input wire logic busy_meas,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic scl_out,
   input wire logic sda_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic cfgd_reg;
   logic [7:0] len_reg;
   // pulse too long to unroll, so counted
   always_ff @(posedge core_clk) begin
      cfgd_reg <= rstn & (cfgd_reg | cfg_write);
      len_reg <= (rstn & scl_oe) ? len_reg + 8'h01 : 8'h00;
   end
   cfg_first_a: assert property (meas_trig && !cfg_write && !cfgd_reg |=> !bias_en)
      else $error("start while unconfigured");
   seq_start_a: assert property (cfg_write && !busy_meas |=> bias_en)
      else $error("no bias after configuration");
   osc_late_a: assert property ($rose(fosc_en) |-> $past(busy_meas, 20))
      else $error("fast oscillator too early");
   hall_x_a: assert property ($rose(hall_bias_en) |-> $past(busy_meas, 30) && mux_sel == 2'h0)
      else $error("probe bias early or not on x");
   supply_halt_a: assert property (!supply_ok [*4] |-> !bias_en && !adc_start)
      else $error("sequencer runs on low supply");
   mux_next_a: assert property (adc_done && mux_sel == 2'h0 |=> mux_sel == 2'h1 && adc_start)
      else $error("y does not follow x");
   int_len_a: assert property ($fell(scl_oe) |-> len_reg == 8'h64)
      else $error("interrupt pulse length wrong");
   pin_low_a: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   int_idle_a: assert property ($rose(scl_oe) |-> $past(scl_in, 3) && $past(sda_in, 3))
      else $error("interrupt on busy bus");
   sda_follow_a: assert property ($past(rstn) |-> sda_oe == $past(sda_low_req))
      else $error("data pin enable wrong");
endmodule
bind mswk_top mswk_monitor i_mswk_monitor (.*);

// file: sim/mswk_bus_master.sv
/* bus master model: pull-ups, one frame per rise of go.
 assumes open-drain enables of the device. */
module mswk_bus_master (
   // control
   input wire logic go,
   // device enables
   input wire logic dev_scl_oe,
   input wire logic dev_sda_oe,
   // resolved lines
   output wire logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   assign scl = m_scl & !dev_scl_oe;
   assign sda = m_sda & !dev_sda_oe;
   // clock stands still between frames
   always @(posedge go) begin
      m_sda = 1'b0;
      #80 m_scl = 1'b0;
      repeat (20) begin
         #40 m_sda = !m_sda;
         #40 m_scl = 1'b1;
         #80 m_scl = 1'b0;
      end
      #40 m_sda = 1'b0;
      #40 m_scl = 1'b1;
      #40 m_sda = 1'b1;
   end
endmodule

// file: sim/test_magnetic_sensor_measure_wakeup.sv
/* bench of the sequencer with converter stand-in.
 assumes the bus master model and checker. */
module test_magnetic_sensor_measure_wakeup;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rstn = 0, cfg_write = 0, cfg_temp_en = 1, cfg_wake_en = 1;
   logic cfg_ca_en = 0, meas_trig = 0, supply_ok = 1, adc_done = 0, sda_low_req = 0;
   logic go = 0, blk = 0, hit, seen, bias_en, fosc_en, hall_bias_en, adc_start, res_valid;
   logic busy_meas, scl_out, scl_oe, sda_out, sda_oe, scl_in, sda_in;
   logic [1:0] mux_sel;
   logic [11:0] adc_data = 0, res_x, res_y, res_z, thr [6], d [4];
   logic [9:0] res_t, last_t = 0;
   logic [15:0] lf = 16'h0052;
   logic [46:0] e, q [$];
   int n_fail = 0, checked = 0, idx = 0, ndone = 0;
   mswk_top i_mswk_top (.*, .thr_hi_x(thr[0]), .thr_lo_x(thr[1]), .thr_hi_y(thr[2]),
      .thr_lo_y(thr[3]), .thr_hi_z(thr[4]), .thr_lo_z(thr[5]));
   mswk_bus_master i_mswk_bus_master (.go, .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe),
      .scl(scl_in), .sda(sda_in));
   always #5 core_clk = !core_clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic ow(input logic [11:0] v, hi, lo);
      return $signed(v) > $signed(hi) || $signed(v) < $signed(lo);
   endfunction
   task cyc;
      @(posedge core_clk);
      #1;
   endtask
   task give_verdict;
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [45:0] g, x);
      checked++;
      if (g !== x) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic run;
      int n0;
      n0 = ndone;
      for (int n = 0; ndone == n0; n++) begin
         if (n == 3000) begin
            n_fail++;
            give_verdict;
         end
         cyc;
      end
   endtask
   task automatic cfg(input logic t, w, c);
      cfg_temp_en = t;
      cfg_wake_en = w;
      cfg_ca_en = c;
      cfg_write = 1;
      cyc;
      cfg_write = 0;
      run;
   endtask
   task automatic trig(input logic drop);
      meas_trig = 1;
      cyc;
      meas_trig = 0;
      if (drop) begin
         repeat (40) cyc;
         supply_ok = 0;
         repeat (10) cyc;
         supply_ok = 1;
      end
      run;
   endtask
   // converter stand-in notes each expected cycle
   always @(posedge core_clk) if (adc_start) begin
      lf = lfsr(lf);
      repeat (4) @(posedge core_clk);
      #1 adc_data = lf[11:0];
      adc_done = 1;
      d[idx] = lf[11:0];
      idx++;
      cyc;
      adc_done = 0;
      adc_data = ~adc_data;
      if (idx == (cfg_temp_en ? 4 : 3)) begin
         if (cfg_temp_en) last_t = d[3][11:2];
         hit = ow(d[0], thr[0], thr[1]) | ow(d[1], thr[2], thr[3]) | ow(d[2], thr[4], thr[5]);
         q.push_back({(!cfg_wake_en | hit) & !blk, last_t, d[2], d[1], d[0]});
         idx = 0;
      end
   end
   always @(posedge core_clk) if (res_valid) begin
      e = q.pop_front();
      chk({res_t, res_z, res_y, res_x}, e[45:0]);
      seen = 0;
      repeat (400) @(posedge core_clk) seen |= scl_oe;
      chk({45'h0, seen}, {45'h0, e[46]});
      ndone++;
   end
   initial begin
      thr = '{12'h7FF, 12'h800, 12'h7FF, 12'h800, 12'h7FF, 12'h800};
      repeat (6) cyc;
      rstn = 1;
      meas_trig = 1;
      for (int i = 0; i < 9; i++) begin
         lf = lfsr(lf);
         sda_low_req = lf[0] | (i == 8);
         cyc;
         meas_trig = 0;
      end
      sda_low_req = 0;
      chk({45'h0, busy_meas}, 46'h0);
      cfg(1, 1, 0);
      for (int k = 0; k < 6; k++) begin
         thr[k] = ~thr[k];
         trig(0);
         thr[k] = ~thr[k];
      end
      cfg(0, 0, 0);
      trig(1);
      rstn = 0;
      repeat (3) cyc;
      rstn = 1;
      meas_trig = 1;
      cyc;
      meas_trig = 0;
      cyc;
      chk({45'h0, busy_meas}, 46'h0);
      chk({res_t, res_z, res_y, res_x}, 46'h0);
      go = 1;
      cfg(1, 0, 0);
      go = 0;
      blk = 1;
      cyc;
      go = 1;
      cfg(1, 0, 1);
      give_verdict;
   end
endmodule
